// ### adc_ctrl.sv
// Clock division, reset/power-down, start-up sequencing, calibration and level flag
`timescale 1ns/100ps
`include "adc_ctrl_map.svh"

module adc_ctrl import adc_ctrl_pkg::*; (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Strap pins
	input wire logic ratio_384_in,
	input wire logic slave_in,
	input wire logic justify_select_in,
	input wire logic first_bit_delay_in,
	input wire logic bit_clock_edge_select_in,
	// Slave-mode clock pins
	input wire logic channel_frame_clock_in,
	input wire logic word_clock_in,
	// Sample magnitude from the decimator
	input wire logic [16:0] sample_mag_in,
	input wire logic sample_valid_in,
	// Serial clock and flag outputs
	output logic bit_clock_out,
	output logic channel_frame_clock_out,
	output logic channel_frame_clock_oe_out,
	output logic word_clock_out,
	output logic word_clock_oe_out,
	output logic tag_out,
	// Converter control
	output logic mod_tick_out,
	output logic filter_clear_out,
	output logic power_down_out,
	output logic calibrating_out,
	output logic sampling_out
);
	state_s st_reg, st_next;
	logic word_in_mode;
	logic div_wrap;
	logic frame_start;
	logic channel_edge;
	logic [7:0] div_max;
	logic lr_now, lr_prev, wc_now;

	// ====================================================================
	// Mode decode
	assign word_in_mode = slave_in & justify_select_in & ~first_bit_delay_in;
	assign div_max = ratio_384_in ? `RATIO_384_DIV : `RATIO_256_DIV;
	assign div_wrap = (st_reg.div_cnt >= div_max);
	assign lr_now = st_reg.lr_sync[1];
	assign lr_prev = st_reg.lr_sync[2];
	assign wc_now = st_reg.wc_sync[2];
	// Frame boundary: own counter in master mode, external frame rise in slave mode
	assign frame_start = slave_in ? (lr_now & ~lr_prev) :
		(div_wrap && st_reg.mod_cnt == 6'h3f);
	// Channel boundary: either frame clock edge, one per channel sample
	assign channel_edge = slave_in ? (lr_now != lr_prev) : (div_wrap && st_reg.mod_cnt[4:0] == 5'h1f);

	// ====================================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.rst_sync = {st_reg.rst_sync[0], 1'b1};
		st_next.lr_sync = {st_reg.lr_sync[1:0], channel_frame_clock_in};
		st_next.wc_sync = {st_reg.wc_sync[1:0], word_clock_in};
		st_next.div_cnt = div_wrap ? 8'h00 : st_reg.div_cnt + 8'h01;
		if (div_wrap && st_reg.seq != ST_IDLE && st_reg.seq != ST_ARM) begin
			st_next.mod_cnt = st_reg.mod_cnt + 6'h01;
		end
		if (!st_reg.rst_sync[1]) begin
			st_next.seq = ST_IDLE;
			st_next.div_cnt = 8'h00;
		end else begin
			unique case (st_reg.seq)
				ST_IDLE: begin
					st_next.seq = slave_in ? ST_ARM : ST_CAL;
					st_next.lr_fell = 1'b0;
					st_next.wc_seen = 2'b00;
					st_next.cal_cnt = 14'h0000;
					st_next.mod_cnt = 6'h00;
					// Bit clock parks at the edge-select level before its first edge
					st_next.pins.bit_clock = bit_clock_edge_select_in;
					st_next.tag_msb_pending = 1'b0;
					st_next.tag_lsb_pending = 1'b0;
				end
				ST_ARM: begin
					if (!lr_now && lr_prev) begin
						st_next.lr_fell = 1'b1;
					end
					if (word_in_mode && wc_now) begin
						if (st_reg.wc_seen == 2'b00 && lr_now) st_next.wc_seen = 2'b01;
						if (st_reg.wc_seen == 2'b01 && !lr_now) st_next.wc_seen = 2'b10;
					end
					if (st_reg.lr_fell && lr_now && !lr_prev &&
						(!word_in_mode || (st_reg.wc_seen == 2'b10 && wc_now))) begin
						st_next.seq = ST_CAL;
						st_next.mod_cnt = 6'h00;
					end
				end
				ST_CAL: begin
					if (frame_start) begin
						st_next.cal_cnt = st_reg.cal_cnt + 14'h0001;
						if (st_reg.cal_cnt == `CAL_FRAMES - 14'd1) st_next.seq = ST_RUN;
					end
				end
				ST_RUN: begin
				end
			endcase
		end
		// Level flag follows every new sample; no peak hold
		if (sample_valid_in) begin
			if (sample_mag_in > `CLIP_NEAR_OVER) st_next.level = 2'b11;
			else if (sample_mag_in > {1'b0, `CLIP_FULL}) st_next.level = 2'b10;
			else if (sample_mag_in >= {1'b0, `CLIP_NEAR_UNDER}) st_next.level = 2'b01;
			else st_next.level = 2'b00;
		end
		// Serial clocks; bit clock toggles at each modulator tick (one bit per tick pair)
		if (st_reg.seq == ST_CAL || st_reg.seq == ST_RUN) begin
			if (div_wrap) st_next.pins.bit_clock = ~st_reg.pins.bit_clock;
			st_next.pins.frame_clock = slave_in ? lr_now : ~st_reg.mod_cnt[5];
			st_next.pins.word_clock = slave_in ? lr_now : ~st_reg.mod_cnt[5];
			// Boundary is latched: it seldom falls on a transmitting edge
			if (channel_edge) st_next.tag_msb_pending = 1'b1;
			// Tag launched on the transmitting edge, MSB after a boundary then LSB
			if (div_wrap && st_reg.pins.bit_clock == bit_clock_edge_select_in) begin
				if (st_reg.tag_msb_pending || channel_edge) begin
					st_next.pins.tag = st_reg.level[1];
					st_next.tag_msb_pending = 1'b0;
					st_next.tag_lsb_pending = 1'b1;
				end else if (st_reg.tag_lsb_pending) begin
					st_next.pins.tag = st_reg.level[0];
					st_next.tag_lsb_pending = 1'b0;
				end else begin
					st_next.pins.tag = 1'b0;
				end
			end
		end
	end

	// ====================================================================
	// Registers; reset takes constants only
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ====================================================================
	// Outputs
	always_comb begin
		// Bit clock rests at the edge-select level through reset and release, no glitch
		bit_clock_out = (st_reg.seq == ST_IDLE) ? bit_clock_edge_select_in : st_reg.pins.bit_clock;
		channel_frame_clock_out = st_reg.pins.frame_clock;
		channel_frame_clock_oe_out = ~slave_in;
		word_clock_out = st_reg.pins.word_clock;
		word_clock_oe_out = ~word_in_mode;
		tag_out = st_reg.pins.tag;
	end
	assign mod_tick_out = div_wrap && (st_reg.seq == ST_CAL || st_reg.seq == ST_RUN);
	assign filter_clear_out = ~st_reg.rst_sync[1];
	assign power_down_out = ~st_reg.rst_sync[1];
	assign calibrating_out = (st_reg.seq == ST_CAL);
	assign sampling_out = (st_reg.seq == ST_RUN);

	// ====================================================================
	// Checks
	cal_entry_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(st_reg.rst_sync[1]) && !slave_in |=> st_reg.seq == ST_CAL)
		else $error("calibration did not start after reset release");
	slave_wait_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		st_reg.seq == ST_ARM && !st_reg.lr_fell |=> st_reg.seq != ST_CAL)
		else $error("slave started before frame clock fell");
	tick_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		st_reg.seq == ST_IDLE |-> !mod_tick_out)
		else $error("modulator ticked in power-down");
	cal_length_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		st_reg.seq == ST_CAL && st_next.seq == ST_RUN |-> st_reg.cal_cnt == `CAL_FRAMES - 14'd1)
		else $error("calibration length wrong");
	wclk_dir_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		word_clock_oe_out == !(slave_in && justify_select_in && !first_bit_delay_in))
		else $error("word clock direction wrong");
	level_top_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		sample_valid_in && sample_mag_in > `CLIP_NEAR_OVER |=> st_reg.level == 2'b11)
		else $error("level flag not full over");
	level_low_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		sample_valid_in && sample_mag_in < {1'b0, `CLIP_NEAR_UNDER} |=> st_reg.level == 2'b00)
		else $error("level flag held stale");
	div_ratio_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ratio_384_in && $stable(ratio_384_in) && div_wrap |-> st_reg.div_cnt == `RATIO_384_DIV)
		else $error("divide ratio wrong");
	tick_256_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		mod_tick_out && !ratio_384_in |=> !mod_tick_out [*3] ##1 mod_tick_out)
		else $error("modulator tick period wrong in 256 mode");
	tick_384_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		mod_tick_out && ratio_384_in |=> !mod_tick_out [*5] ##1 mod_tick_out)
		else $error("modulator tick period wrong in 384 mode");
	idle_pins_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		st_reg.seq == ST_IDLE |-> bit_clock_out == bit_clock_edge_select_in &&
		!tag_out && !word_clock_out && !channel_frame_clock_out)
		else $error("pins not parked before start-up");
	slave_static_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		st_reg.seq == ST_ARM |=> $stable(bit_clock_out) && $stable(channel_frame_clock_out) &&
		$stable(word_clock_out) && $stable(tag_out))
		else $error("outputs moved while slave start-up was pending");
	sync_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!st_reg.rst_sync[1] |=> st_reg.seq == ST_IDLE && !mod_tick_out)
		else $error("sequencing left idle before reset release was synchronised");
endmodule // adc_ctrl

// ### adc_ctrl_map.svh
// Constants for the converter clock, reset and level-flag control block
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH
`define RATIO_384_DIV 8'd5
`define RATIO_256_DIV 8'd3
`define MOD_PER_FRAME 8'd64
`define CAL_FRAMES 14'd8192
`define CLIP_NEAR_UNDER 16'h6e00
`define CLIP_FULL 16'h7fff
`define CLIP_NEAR_OVER 17'h0_8f00
`endif

// ### adc_ctrl_pkg.sv
// Types for the converter clock, reset and level-flag control block
package adc_ctrl_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARM = 2'b01,
		ST_CAL = 2'b10,
		ST_RUN = 2'b11
	} seq_e;
	typedef struct packed {
		logic bit_clock;
		logic frame_clock;
		logic word_clock;
		logic tag;
	} pins_s;
	typedef struct packed {
		logic [1:0] rst_sync;
		logic [2:0] lr_sync;
		logic [2:0] wc_sync;
		logic lr_fell;
		logic [1:0] wc_seen;
		seq_e seq;
		logic [7:0] div_cnt;
		logic [5:0] mod_cnt;
		logic [13:0] cal_cnt;
		logic [1:0] level;
		logic tag_msb_pending;
		logic tag_lsb_pending;
		pins_s pins;
	} state_s;
endpackage

// ### adc_ctrl_tb.sv
// Testbench: reset levels, pin direction, clock division and start-up
`timescale 1ns/100ps
`include "adc_ctrl_map.svh"
module adc_ctrl_tb;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic ratio_384_in = 1'b0;
	logic slave_in = 1'b0;
	logic justify_select_in = 1'b0;
	logic first_bit_delay_in = 1'b0;
	logic bit_clock_edge_select_in = 1'b0;
	logic frame_en = 1'b0;
	logic word_en = 1'b1;
	logic [16:0] sample_mag_in = 17'h0_0000;
	logic sample_valid_in = 1'b0;
	logic channel_frame_clock_in, word_clock_in, bit_clock_out, channel_frame_clock_out;
	logic channel_frame_clock_oe_out, word_clock_out, word_clock_oe_out, tag_out, mod_tick_out;
	logic filter_clear_out, power_down_out, calibrating_out, sampling_out;
	logic [7:0] gap;
	int bad_count = 0;
	int comparisons = 0;
	int cycles = 0;
	always #5 clk_in = ~clk_in;
	adc_ctrl uut (.clk_in, .rst_n_in, .ratio_384_in, .slave_in, .justify_select_in, .first_bit_delay_in,
		.bit_clock_edge_select_in, .channel_frame_clock_in, .word_clock_in, .sample_mag_in,
		.sample_valid_in, .bit_clock_out, .channel_frame_clock_out, .channel_frame_clock_oe_out,
		.word_clock_out, .word_clock_oe_out, .tag_out, .mod_tick_out, .filter_clear_out,
		.power_down_out, .calibrating_out, .sampling_out);
	adc_frame_src src (.clk_in, .enable_in(frame_en), .word_en_in(word_en),
		.channel_frame_clock_out(channel_frame_clock_in), .word_clock_out(word_clock_in));
	// ==========================================
	// Tasks
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Straps are {edge select, slave, justify, first-bit delay}
	task automatic hold_reset(input logic [3:0] s);
		@(posedge clk_in);
		#1;
		rst_n_in = 1'b0;
		{bit_clock_edge_select_in, slave_in, justify_select_in, first_bit_delay_in} = s;
		repeat (5) @(posedge clk_in);
		#1;
	endtask
	task automatic release_reset();
		@(negedge clk_in);
		rst_n_in = 1'b1;
		repeat (10) @(posedge clk_in);
		#1;
	endtask
	// Sampled on falling edges, clear of the launching edge
	task automatic tick_gap();
		gap = 8'h00;
		@(negedge clk_in);
		while (mod_tick_out !== 1'b1) @(negedge clk_in);
		do begin
			@(negedge clk_in);
			gap++;
		end while (mod_tick_out !== 1'b1);
	endtask
	// Tag bits taken at the valid bit-clock edges after a frame clock change
	task automatic tag_pair(output logic [1:0] pair);
		logic lr;
		@(negedge clk_in);
		lr = channel_frame_clock_out;
		while (channel_frame_clock_out === lr) @(negedge clk_in);
		for (int k = 1; k >= 0; k--) begin
			while (bit_clock_out !== ~bit_clock_edge_select_in) @(negedge clk_in);
			while (bit_clock_out !== bit_clock_edge_select_in) @(negedge clk_in);
			pair[k] = tag_out;
		end
	endtask
	task automatic tag_case(input logic [16:0] mag, input logic [7:0] exp);
		logic [1:0] pair;
		@(posedge clk_in);
		#1;
		sample_mag_in = mag;
		sample_valid_in = 1'b1;
		@(posedge clk_in);
		#1;
		sample_valid_in = 1'b0;
		tag_pair(pair);
		check("tag pair", exp, {6'h00, pair});
	endtask
	// ==========================================
	// Tests
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			conclude();
		end
	end
	initial begin
		for (int i = 0; i < 16; i++) begin
			hold_reset(i[3:0]);
			check("bit clock", {7'h00, i[3]}, {7'h00, bit_clock_out});
			check("outputs", 8'h00, {channel_frame_clock_out, word_clock_out, tag_out, sampling_out});
			check("power", 8'h03, {calibrating_out, mod_tick_out, filter_clear_out, power_down_out});
			check("oe", {6'h00, ~i[2], ~(i[2] & i[1] & ~i[0])},
				{6'h00, channel_frame_clock_oe_out, word_clock_oe_out});
		end
		$display("Test reset and pin direction done");
		for (int r = 0; r < 2; r++) begin
			hold_reset(4'h0);
			ratio_384_in = r[0];
			release_reset();
			check("start", 8'h02, {filter_clear_out, power_down_out, calibrating_out, sampling_out});
			tick_gap();
			check("tick gap", (r == 1) ? 8'h06 : 8'h04, gap);
		end
		$display("Test master ratio done");
		hold_reset(4'h5);
		release_reset();
		repeat (200) @(posedge clk_in);
		#1;
		check("slave idle", 8'h00, {word_clock_out, tag_out, calibrating_out, sampling_out});
		frame_en = 1'b1;
		repeat (200) @(posedge clk_in);
		#1;
		check("slave cal", 8'h01, {7'h00, calibrating_out});
		hold_reset(4'h6);
		word_en = 1'b0;
		release_reset();
		repeat (200) @(posedge clk_in);
		#1;
		check("word clock start", 8'h00, {7'h00, calibrating_out});
		word_en = 1'b1;
		repeat (200) @(posedge clk_in);
		#1;
		check("word clock start", 8'h01, {7'h00, calibrating_out});
		$display("Test slave start done");
		frame_en = 1'b0;
		hold_reset(4'h0);
		ratio_384_in = 1'b0;
		release_reset();
		tag_case(`CLIP_NEAR_OVER + 17'h0_0001, 8'h03);
		tag_case({1'b0, `CLIP_FULL} + 17'h0_0001, 8'h02);
		hold_reset(4'h8);
		release_reset();
		tag_case({1'b0, `CLIP_NEAR_UNDER}, 8'h01);
		tag_case({1'b0, `CLIP_NEAR_UNDER} - 17'h0_0001, 8'h00);
		$display("Test level flag done");
		conclude();
	end
endmodule // adc_ctrl_tb

// ### adc_frame_src.sv
// Far-side model: slave-mode frame and word clock source
`timescale 1ns/100ps
module adc_frame_src #(parameter int HALF = 32) (
	// Clock and control
	input wire logic clk_in,
	input wire logic enable_in,
	input wire logic word_en_in,
	// Slave clocks
	output logic channel_frame_clock_out,
	output logic word_clock_out
);
	int cnt = 0;
	// ==========================================
	// Frame clock
	// Divided from the master clock, never free-running
	always @(posedge clk_in) begin
		if (!enable_in) begin
			cnt <= #1 0;
			channel_frame_clock_out <= #1 1'b1;
		end else if (cnt == HALF - 1) begin
			cnt <= #1 0;
			channel_frame_clock_out <= #1 ~channel_frame_clock_out;
		end else begin
			cnt <= #1 cnt + 1;
		end
	end
	// Held low to stall the start pattern, high to let it complete
	assign word_clock_out = word_en_in;
endmodule // adc_frame_src
